/* core/rpec_counter_bank.sv */
// Receive performance counter bank: error, severe frame and slip counters on APB
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
module rpec_counter_bank #(
   parameter logic [4:0] SF_RUN  = rpec_pkg::SEF_SF_RUN,  // Errored superframes, SF
   parameter logic [4:0] ESF_RUN = rpec_pkg::SEF_ESF_RUN  // Errored superframes, ESF
) (
   input  wire logic        pclk,              // Clock, 100 MHz
   input  wire logic        presetn,           // Asynchronous reset, active low
   input  wire logic [13:0] paddr,             // APB byte address
   input  wire logic        psel,              // APB select
   input  wire logic        penable,           // APB access phase
   input  wire logic        pwrite,            // APB write
   input  wire logic [31:0] pwdata,            // APB write data
   output logic      [31:0] prdata,            // APB read data
   output logic             pready,            // APB ready
   output logic             pslverr,           // APB error, unmapped address
   input  wire logic        fae_err_pulse,     // Framing alignment bit error
   input  wire logic        crc6_err_pulse,    // CRC-6 sync bit error
   input  wire logic        fbit_check,        // Superframe framing bits checked
   input  wire logic        fbit_err,          // Those framing bits were in error
   input  wire logic        esf_mode,          // 1 extended superframe, 0 superframe
   input  wire logic        slip_frame_repeat, // Slip buffer repeated a frame
   input  wire logic        slip_frame_drop,   // Slip buffer dropped a frame
   output logic             irq                // Interrupt, high while enabled status set
);
   rpec_cnt_if #(.W(rpec_pkg::WIDE_W))   fae_if ();
   rpec_cnt_if #(.W(rpec_pkg::WIDE_W))   crc_if ();
   rpec_cnt_if #(.W(rpec_pkg::NARROW_W)) sef_if ();
   rpec_cnt_if #(.W(rpec_pkg::NARROW_W)) slip_if ();

   logic [31:0]              prdata_ff;
   logic [31:0]              nxt_rdata;
   logic [15:0]              fae_snap_ff;
   logic [15:0]              crc_snap_ff;
   logic                     fae_arm_ff;
   logic                     crc_arm_ff;
   logic [4:0]               run_ff;
   logic                     sef_event;
   logic [rpec_pkg::NUM_EV-1:0] stat_ff;
   logic [rpec_pkg::NUM_EV-1:0] en_ff;
   logic [rpec_pkg::NUM_EV-1:0] ev_vec;
   logic                     setup;
   logic                     acc_rd;
   logic                     acc_wr;
   logic                     mapped;

   // Word index hit on an aligned address
   function automatic logic hit(input logic [13:0] a, input logic [11:0] i);
      hit = (a[13:2] == i) && (a[1:0] == 2'b00);
   endfunction

   // APB phase decode; zero wait states, so pready is high throughout
   assign setup   = psel && !penable;
   assign acc_rd  = psel && penable && !pwrite;
   assign acc_wr  = psel && penable && pwrite;
   assign pready  = 1'b1;
   assign mapped  = hit(paddr, rpec_pkg::IDX_FAE_HI) || hit(paddr, rpec_pkg::IDX_FAE_LO)
                 || hit(paddr, rpec_pkg::IDX_SEF)    || hit(paddr, rpec_pkg::IDX_CRC_HI)
                 || hit(paddr, rpec_pkg::IDX_CRC_LO) || hit(paddr, rpec_pkg::IDX_SLIP)
                 || hit(paddr, rpec_pkg::IDX_INT_STAT) || hit(paddr, rpec_pkg::IDX_INT_EN)
                 || hit(paddr, rpec_pkg::IDX_INT_CLR);
   assign pslverr = psel && penable && !mapped;
   assign prdata  = prdata_ff;

   // Read mux; a low byte read after an upper byte read returns the snapshot
   always_comb
   begin
      nxt_rdata = rpec_pkg::RDATA_RST;
      unique case (1'b1)
         hit(paddr, rpec_pkg::IDX_FAE_HI):
            nxt_rdata[7:0] = fae_if.count[15:8];
         hit(paddr, rpec_pkg::IDX_FAE_LO):
            nxt_rdata[7:0] = fae_arm_ff ? fae_snap_ff[7:0] : fae_if.count[7:0];
         hit(paddr, rpec_pkg::IDX_SEF):
            nxt_rdata[7:0] = sef_if.count;
         hit(paddr, rpec_pkg::IDX_CRC_HI):
            nxt_rdata[7:0] = crc_if.count[15:8];
         hit(paddr, rpec_pkg::IDX_CRC_LO):
            nxt_rdata[7:0] = crc_arm_ff ? crc_snap_ff[7:0] : crc_if.count[7:0];
         hit(paddr, rpec_pkg::IDX_SLIP):
            nxt_rdata[7:0] = slip_if.count;
         hit(paddr, rpec_pkg::IDX_INT_STAT):
            nxt_rdata[rpec_pkg::NUM_EV-1:0] = stat_ff;
         hit(paddr, rpec_pkg::IDX_INT_EN):
            nxt_rdata[rpec_pkg::NUM_EV-1:0] = en_ff;
         default:
            nxt_rdata = rpec_pkg::RDATA_RST;
      endcase
   end

   // Read data is captured in the setup cycle so prdata comes from a flop
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_ff <= rpec_pkg::RDATA_RST;
      else if (setup && !pwrite)
         prdata_ff <= nxt_rdata;
   end

   // Upper byte read snapshots the whole count and arms the lower byte read
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fae_snap_ff <= rpec_pkg::CNT_RST;
         fae_arm_ff  <= 1'b0;
      end
      else if (setup && !pwrite && hit(paddr, rpec_pkg::IDX_FAE_HI))
         fae_snap_ff <= fae_if.count;
      else if (acc_rd && hit(paddr, rpec_pkg::IDX_FAE_HI))
         fae_arm_ff  <= 1'b1;
      else if (acc_rd && hit(paddr, rpec_pkg::IDX_FAE_LO))
         fae_arm_ff  <= 1'b0;
   end

   // Same pairing for the CRC-6 counter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         crc_snap_ff <= rpec_pkg::CNT_RST;
         crc_arm_ff  <= 1'b0;
      end
      else if (setup && !pwrite && hit(paddr, rpec_pkg::IDX_CRC_HI))
         crc_snap_ff <= crc_if.count;
      else if (acc_rd && hit(paddr, rpec_pkg::IDX_CRC_HI))
         crc_arm_ff  <= 1'b1;
      else if (acc_rd && hit(paddr, rpec_pkg::IDX_CRC_LO))
         crc_arm_ff  <= 1'b0;
   end

   // Wide counters clear only on the armed lower byte read, by the snapshot
   assign fae_if.inc  = fae_err_pulse;
   assign fae_if.clr  = acc_rd && hit(paddr, rpec_pkg::IDX_FAE_LO) && fae_arm_ff;
   assign fae_if.sub  = fae_snap_ff;
   assign crc_if.inc  = crc6_err_pulse;
   assign crc_if.clr  = acc_rd && hit(paddr, rpec_pkg::IDX_CRC_LO) && crc_arm_ff;
   assign crc_if.sub  = crc_snap_ff;

   // Narrow counters subtract the value returned, so late events survive
   assign sef_if.inc  = sef_event;
   assign sef_if.clr  = acc_rd && hit(paddr, rpec_pkg::IDX_SEF);
   assign sef_if.sub  = prdata_ff[7:0];
   assign slip_if.inc = slip_frame_repeat || slip_frame_drop;
   assign slip_if.clr = acc_rd && hit(paddr, rpec_pkg::IDX_SLIP);
   assign slip_if.sub = prdata_ff[7:0];

   rpec_sat_counter #(.W(rpec_pkg::WIDE_W)) u_fae_cnt (
      .pclk    (pclk),
      .presetn (presetn),
      .cnt_bus (fae_if.cnt)
   );
   rpec_sat_counter #(.W(rpec_pkg::WIDE_W)) u_crc_cnt (
      .pclk    (pclk),
      .presetn (presetn),
      .cnt_bus (crc_if.cnt)
   );
   rpec_sat_counter #(.W(rpec_pkg::NARROW_W)) u_sef_cnt (
      .pclk    (pclk),
      .presetn (presetn),
      .cnt_bus (sef_if.cnt)
   );
   rpec_sat_counter #(.W(rpec_pkg::NARROW_W)) u_slip_cnt (
      .pclk    (pclk),
      .presetn (presetn),
      .cnt_bus (slip_if.cnt)
   );

   // Severe frame event on the last errored superframe of a full run;
   // a run carried across a mode change declares at once rather than wrapping
   assign sef_event = fbit_check && fbit_err
                   && (run_ff + 5'h01 >= (esf_mode ? ESF_RUN : SF_RUN));

   // Run of consecutive errored superframes; a good one restarts it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         run_ff <= 5'h00;
      else if (fbit_check)
         run_ff <= (!fbit_err || sef_event) ? 5'h00 : run_ff + 5'h01;
   end

   // Sticky status; an event in the clearing cycle wins over the clear
   assign ev_vec = {slip_if.inc, crc_if.inc, sef_event, fae_if.inc};
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         stat_ff <= '0;
      else if (acc_wr && hit(paddr, rpec_pkg::IDX_INT_CLR))
         stat_ff <= (stat_ff & ~pwdata[rpec_pkg::NUM_EV-1:0]) | ev_vec;
      else
         stat_ff <= stat_ff | ev_vec;
   end

   // Interrupt enable register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         en_ff <= rpec_pkg::INT_EN_RST;
      else if (acc_wr && hit(paddr, rpec_pkg::IDX_INT_EN))
         en_ff <= pwdata[rpec_pkg::NUM_EV-1:0];
   end

   assign irq = |(stat_ff & en_ff);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Checks on pairing, run detection and clear-on-read
   sequence fae_hi_rd_s;
      setup && !pwrite && hit(paddr, rpec_pkg::IDX_FAE_HI) ##1 acc_rd;
   endsequence
   sequence fae_lo_rd_s;
      setup && !pwrite && hit(paddr, rpec_pkg::IDX_FAE_LO) ##1 acc_rd;
   endsequence
   sequence crc_hi_rd_s;
      setup && !pwrite && hit(paddr, rpec_pkg::IDX_CRC_HI) ##1 acc_rd;
   endsequence
   sequence crc_lo_rd_s;
      setup && !pwrite && hit(paddr, rpec_pkg::IDX_CRC_LO) ##1 acc_rd;
   endsequence
   // Reads with no event in setup or access must leave the counter at zero
   sequence slip_quiet_rd_s;
      setup && !pwrite && hit(paddr, rpec_pkg::IDX_SLIP) && !slip_if.inc
      ##1 acc_rd && !slip_if.inc;
   endsequence
   sequence sef_quiet_rd_s;
      setup && !pwrite && hit(paddr, rpec_pkg::IDX_SEF) && !sef_event
      ##1 acc_rd && !sef_event;
   endsequence

   // A lower byte read that was not armed may only let the count grow
   lo_unarmed_a: assert property (acc_rd && !fae_arm_ff
                                  && hit(paddr, rpec_pkg::IDX_FAE_LO)
                                  |=> fae_if.count >= $past(fae_if.count))
      else $error("wide counter cleared without upper byte read");
   // The bus may idle for one cycle between the two reads of a pair
   pair_clear_a: assert property (fae_hi_rd_s ##[1:2] fae_lo_rd_s |-> fae_if.clr)
      else $error("upper then lower read did not clear");
   hi_byte_a: assert property (setup && !pwrite && hit(paddr, rpec_pkg::IDX_FAE_HI)
                               |=> prdata_ff[7:0] == $past(fae_if.count[15:8]))
      else $error("upper byte read wrong bits");
   lo_snap_a: assert property (fae_arm_ff && setup && !pwrite && hit(paddr, rpec_pkg::IDX_FAE_LO)
                               |=> prdata_ff[7:0] == fae_snap_ff[7:0])
      else $error("lower byte not taken from snapshot");
   crc_arm_a: assert property (acc_rd && hit(paddr, rpec_pkg::IDX_CRC_HI)
                               |=> crc_arm_ff && crc_snap_ff == $past(crc_snap_ff))
      else $error("crc upper read did not arm");
   crc_pair_a: assert property (crc_hi_rd_s ##[1:2] crc_lo_rd_s |-> crc_if.clr)
      else $error("crc upper then lower read did not clear");
   crc_unarmed_a: assert property (acc_rd && !crc_arm_ff
                                   && hit(paddr, rpec_pkg::IDX_CRC_LO)
                                   |=> crc_if.count >= $past(crc_if.count))
      else $error("crc counter cleared without upper byte read");
   crc_hi_byte_a: assert property (setup && !pwrite && hit(paddr, rpec_pkg::IDX_CRC_HI)
                                   |=> prdata_ff[7:0] == $past(crc_if.count[15:8]))
      else $error("crc upper byte read wrong bits");
   crc_lo_snap_a: assert property (crc_arm_ff && setup && !pwrite
                                   && hit(paddr, rpec_pkg::IDX_CRC_LO)
                                   |=> prdata_ff[7:0] == crc_snap_ff[7:0])
      else $error("crc lower byte not taken from snapshot");
   arm_drop_a: assert property (acc_rd && hit(paddr, rpec_pkg::IDX_FAE_LO)
                                |=> !fae_arm_ff)
      else $error("lower byte read left the pair armed");
   sf_run_a: assert property (!esf_mode && run_ff == 5'h05 && fbit_check && fbit_err
                              |-> sef_event ##1 run_ff == 5'h00)
      else $error("sixth errored superframe missed");
   esf_run_a: assert property (esf_mode && run_ff == 5'h16 && fbit_check && fbit_err
                               |-> !sef_event ##1 run_ff == 5'h17)
      else $error("extended run declared early");
   esf_decl_a: assert property (esf_mode && run_ff == 5'h17 && fbit_check && fbit_err
                                |-> sef_event ##1 run_ff == 5'h00)
      else $error("24th errored superframe missed");
   good_frame_a: assert property (fbit_check && !fbit_err |=> run_ff == 5'h00)
      else $error("good superframe did not restart the run");
   hold_run_a: assert property (!fbit_check |=> run_ff == $past(run_ff))
      else $error("run moved without a framing check");

   // Both slip kinds in one cycle still count a single slip
   slip_count_a: assert property (slip_frame_repeat && slip_frame_drop && !slip_if.clr
                                  && slip_if.count < 8'hFE
                                  |=> slip_if.count == $past(slip_if.count) + 8'h01)
      else $error("slip event not counted once");
   slip_read_a: assert property (slip_quiet_rd_s |=> slip_if.count == 8'h00)
      else $error("slip read did not clear returned value");
   sef_read_a: assert property (sef_quiet_rd_s |=> sef_if.count == 8'h00)
      else $error("severe frame read did not clear");
   sef_feed_a: assert property (sef_event && !sef_if.clr && sef_if.count != 8'hFF
                                |=> sef_if.count == $past(sef_if.count) + 8'h01)
      else $error("severe frame event not counted");
   // Counter registers ignore software writes
   wr_ignored_a: assert property (acc_wr && hit(paddr, rpec_pkg::IDX_SLIP)
                                  && !slip_if.inc
                                  |=> slip_if.count == $past(slip_if.count))
      else $error("write changed the slip counter");
   set_wins_a: assert property (ev_vec[rpec_pkg::EV_SLIP] && acc_wr
                                && hit(paddr, rpec_pkg::IDX_INT_CLR)
                                |=> stat_ff[rpec_pkg::EV_SLIP])
      else $error("status event lost under clear");
endmodule // rpec_counter_bank

/* core/rpec_sat_counter.sv */
// Saturating event counter with subtract-on-read clearing
`timescale 1ns/10ps
module rpec_sat_counter #(
   parameter int W = 8
) (
   input  wire logic pclk,     // Clock
   input  wire logic presetn,  // Asynchronous reset, active low
   rpec_cnt_if.cnt   cnt_bus   // Event and clear port
);
   logic [W-1:0] count_ff;
   logic [W-1:0] base;
   logic [W-1:0] nxt_count;

   // Subtracting what software saw keeps events that came after it was sampled
   always_comb
   begin
      base = cnt_bus.clr ? count_ff - cnt_bus.sub : count_ff;
      nxt_count = base;
      if (cnt_bus.inc && base != {W{1'b1}})
         nxt_count = base + {{(W-1){1'b0}}, 1'b1};
   end

   // Count register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_ff <= '0;
      else
         count_ff <= nxt_count;
   end

   assign cnt_bus.count = count_ff;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sat_hold_a: assert property (count_ff == {W{1'b1}} && !cnt_bus.clr
                                |=> count_ff == {W{1'b1}})
      else $error("counter left saturation without a read");
   inc_step_a: assert property (cnt_bus.inc && !cnt_bus.clr && count_ff != {W{1'b1}}
                                |=> count_ff == $past(count_ff) + 1'b1)
      else $error("counter missed an event");
endmodule // rpec_sat_counter

/* inc/rpec_cnt_if.sv */
// Connection between the register bank and one saturating event counter
`timescale 1ns/10ps
interface rpec_cnt_if #(parameter int W = 8);
   logic         inc;   // One event this cycle
   logic         clr;   // Read completed, subtract the value returned
   logic [W-1:0] sub;   // Value that was returned to software
   logic [W-1:0] count; // Current count
   modport owner (output inc, output clr, output sub, input count);
   modport cnt   (input inc, input clr, input sub, output count);
endinterface

/* inc/rpec_pkg.sv */
// Register map, field positions and constants of the receive performance counter bank
package rpec_pkg;
   // APB byte address width; registers sit at byte address = index * 4
   localparam int          ADDR_W       = 14;
   localparam int          IDX_W        = 12;
   localparam logic [11:0] IDX_FAE_HI   = 12'h902;
   localparam logic [11:0] IDX_FAE_LO   = 12'h903;
   localparam logic [11:0] IDX_SEF      = 12'h904;
   localparam logic [11:0] IDX_CRC_HI   = 12'h906;
   localparam logic [11:0] IDX_CRC_LO   = 12'h907;
   localparam logic [11:0] IDX_SLIP     = 12'h909;
   localparam logic [11:0] IDX_INT_STAT = 12'h910;
   localparam logic [11:0] IDX_INT_EN   = 12'h911;
   localparam logic [11:0] IDX_INT_CLR  = 12'h912;

   // Counter widths
   localparam int          WIDE_W       = 16;
   localparam int          NARROW_W     = 8;
   localparam int          BYTE_W       = 8;

   // Event bit positions in the status, enable and clear registers
   localparam int          NUM_EV       = 4;
   localparam int          EV_FAE       = 0;
   localparam int          EV_SEF       = 1;
   localparam int          EV_CRC       = 2;
   localparam int          EV_SLIP      = 3;

   // Reset values
   localparam logic [15:0] CNT_RST      = 16'h0000;
   localparam logic [3:0]  INT_EN_RST   = 4'h0;
   localparam logic [31:0] RDATA_RST    = 32'h0000_0000;

   // Consecutive errored superframes that declare a severely errored frame
   localparam int          RUN_W        = 5;
   localparam logic [4:0]  SEF_SF_RUN   = 5'h06;
   localparam logic [4:0]  SEF_ESF_RUN  = 5'h18;
endpackage

/* tb/tb.sv */
// Self-checking testbench for the receive performance counter bank
`timescale 1ns/10ps
module tb;
   typedef struct {
      logic [5:0]  ev;   // Event inputs pulsed
      logic        mode; // Extended superframe mode
      int          n;    // Number of pulses
      logic        wide; // Counter has an upper byte at index - 1
      logic [11:0] idx;  // Lower or only byte index
      logic [15:0] exp;  // Expected count
   } rpec_row_t;

   logic        pclk, presetn, psel, penable, pwrite, esf_mode, pready, pslverr, irq, err;
   logic [13:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0]  ev;
   logic [15:0] e;
   int          errors, checks;
   // Superframe rows first; every run but the 23-pulse and the last 1-pulse ones ends on a whole multiple
   rpec_row_t   rows [13] = '{
      '{6'h01, 1'b0,   3, 1'b1, rpec_pkg::IDX_FAE_LO, 16'h0003},
      '{6'h01, 1'b0, 300, 1'b1, rpec_pkg::IDX_FAE_LO, 16'h012C},
      '{6'h02, 1'b0,   5, 1'b1, rpec_pkg::IDX_CRC_LO, 16'h0005},
      '{6'h02, 1'b0, 257, 1'b1, rpec_pkg::IDX_CRC_LO, 16'h0101},
      '{6'h04, 1'b0,   2, 1'b0, rpec_pkg::IDX_SLIP,   16'h0002},
      '{6'h08, 1'b0,   3, 1'b0, rpec_pkg::IDX_SLIP,   16'h0003},
      '{6'h0C, 1'b0,   4, 1'b0, rpec_pkg::IDX_SLIP,   16'h0004},
      '{6'h30, 1'b0,   6, 1'b0, rpec_pkg::IDX_SEF,    16'h0001},
      '{6'h30, 1'b0,  12, 1'b0, rpec_pkg::IDX_SEF,    16'h0002},
      '{6'h30, 1'b1,  24, 1'b0, rpec_pkg::IDX_SEF,    16'h0001},
      '{6'h30, 1'b1,  23, 1'b0, rpec_pkg::IDX_SEF,    16'h0000},
      '{6'h10, 1'b1,   1, 1'b0, rpec_pkg::IDX_SEF,    16'h0000},
      '{6'h30, 1'b1,   1, 1'b0, rpec_pkg::IDX_SEF,    16'h0000}};
   logic [11:0] rst_idx [7] = '{12'h902, 12'h903, 12'h904, 12'h906, 12'h907, 12'h909, 12'h911};

   rpec_counter_bank i_rpec_counter_bank (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fae_err_pulse(ev[0]), .crc6_err_pulse(ev[1]), .slip_frame_repeat(ev[2]),
      .slip_frame_drop(ev[3]), .fbit_check(ev[4]), .fbit_err(ev[5]), .esf_mode(esf_mode),
      .irq(irq));

   // Free-running 100 MHz clock
   always #5 pclk = ~pclk;

   task report_and_stop;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task chk_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; request held until pready is seen high, bounded wait
   task apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= {idx, 2'b00};
      pwrite  <= wr;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         errors++;
         report_and_stop();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task rd_reg(input logic [11:0] idx);
      apb(1'b0, idx, 32'h0000_0000);
   endtask

   // Pulses are spaced by an idle cycle, as a framer would issue them
   task pulse(input logic [5:0] v, input int n);
      repeat (n)
      begin
         @(posedge pclk);
         ev <= v;
         @(posedge pclk);
         ev <= 6'h00;
      end
   endtask

   initial
   begin
      pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 14'h0000; pwdata = 32'h0000_0000; ev = 6'h00; esf_mode = 1'b0;
      errors = 0; checks = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      // Table rows: count, read upper then lower byte (narrow counters: the only byte), then expect the cleared value
      foreach (rows[i])
      begin
         esf_mode <= rows[i].mode;
         pulse(rows[i].ev, rows[i].n);
         for (int k = 0; k < 2; k++)
         begin
            e = (k == 0) ? rows[i].exp : 16'h0000;
            if (rows[i].wide)
            begin
               rd_reg(rows[i].idx - 12'h001);
               chk(rd, {24'h000000, e[15:8]});
            end
            rd_reg(rows[i].idx);
            chk(rd, {24'h000000, e[7:0]});
         end
      end
      // Unmapped index is refused, and counters ignore writes
      rd_reg(12'h905);
      chk_bit(err, 1'b1);
      chk(rd, 32'h0000_0000);
      apb(1'b1, rpec_pkg::IDX_SLIP, 32'h0000_00FF);
      rd_reg(rpec_pkg::IDX_SLIP);
      chk(rd, 32'h0000_0000);
      // Lower read alone must not clear; events after the snapshot survive
      pulse(6'h01, 4);
      rd_reg(rpec_pkg::IDX_FAE_LO);
      rd_reg(rpec_pkg::IDX_FAE_LO);
      chk(rd, 32'h0000_0004);
      rd_reg(rpec_pkg::IDX_FAE_HI);
      pulse(6'h01, 1);
      rd_reg(rpec_pkg::IDX_FAE_LO);
      chk(rd, 32'h0000_0004);
      rd_reg(rpec_pkg::IDX_FAE_HI);
      rd_reg(rpec_pkg::IDX_FAE_LO);
      chk(rd, 32'h0000_0001);
      // CRC-6 lower read alone keeps the count; the pair then returns it
      pulse(6'h02, 2);
      rd_reg(rpec_pkg::IDX_CRC_LO);
      chk(rd, 32'h0000_0002);
      rd_reg(rpec_pkg::IDX_CRC_HI);
      rd_reg(rpec_pkg::IDX_CRC_LO);
      chk(rd, 32'h0000_0002);
      // Saturation at all ones
      pulse(6'h04, 260);
      rd_reg(rpec_pkg::IDX_SLIP);
      chk(rd, 32'h0000_00FF);
      // Event in the access cycle of the clearing read is kept
      pulse(6'h04, 3);
      fork
         rd_reg(rpec_pkg::IDX_SLIP);
         begin
            repeat (2) @(posedge pclk);
            ev <= 6'h04;
            @(posedge pclk);
            ev <= 6'h00;
         end
      join
      chk(rd, 32'h0000_0003);
      rd_reg(rpec_pkg::IDX_SLIP);
      chk(rd, 32'h0000_0001);
      // Interrupt: clear, masked event, enable, clear again
      apb(1'b1, rpec_pkg::IDX_INT_CLR, 32'h0000_000F);
      rd_reg(rpec_pkg::IDX_INT_STAT);
      chk(rd, 32'h0000_0000);
      pulse(6'h01, 1);
      @(posedge pclk);
      chk_bit(irq, 1'b0);
      apb(1'b1, rpec_pkg::IDX_INT_EN, 32'h0000_0001);
      @(posedge pclk);
      chk_bit(irq, 1'b1);
      pulse(6'h08, 1);
      rd_reg(rpec_pkg::IDX_INT_STAT);
      chk(rd, 32'h0000_0009);
      apb(1'b1, rpec_pkg::IDX_INT_CLR, 32'h0000_0001);
      @(posedge pclk);
      chk_bit(irq, 1'b0);
      rd_reg(rpec_pkg::IDX_INT_CLR);
      chk(rd, 32'h0000_0000);
      // Slip event in the access cycle of a status clear keeps its bit
      fork
         apb(1'b1, rpec_pkg::IDX_INT_CLR, 32'h0000_0008);
         begin
            repeat (2) @(posedge pclk);
            ev <= 6'h08;
            @(posedge pclk);
            ev <= 6'h00;
         end
      join
      rd_reg(rpec_pkg::IDX_INT_STAT);
      chk(rd, 32'h0000_0008);
      // Second reset in mid-run returns everything to zero
      pulse(6'h03, 5);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk_bit(irq, 1'b0);
      foreach (rst_idx[i])
      begin
         rd_reg(rst_idx[i]);
         chk(rd, 32'h0000_0000);
      end
      report_and_stop();
   end
endmodule // tb
